// File: hpm_regs.svh
/*
  Timing counts and pin encodings for the processor port and its mode straps.
  Assumes inclusion by bare name from the package and both port ends.
*/
`ifndef HPM_REGS_SVH
`define HPM_REGS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define HPM_CLK_MHZ 10
`define HPM_PCLK_MAX_MHZ 16
// half period of the generated processor clock, rounded up, at least 1
`define HPM_PCLK_HALF_CYC ((`HPM_CLK_MHZ + 2 * `HPM_PCLK_MAX_MHZ - 1) / (2 * `HPM_PCLK_MAX_MHZ))
// one less than the cycles the address strobe phases stand, covers the far synchroniser
`define HPM_ALE_CYC 4

// ----------------------------------------------------------------
// pin encodings and reset values
// ----------------------------------------------------------------
`define HPM_MODE_HOST 1'b0
`define HPM_MODE_HW 1'b1
`define HPM_DATA_IDLE 8'hff
`define HPM_PIN_RESET 1'b1
// synchroniser reset: straps and strobes high, address strobe low
`define HPM_SYNC_IDLE 20'hfefff

`endif

// File: hpm_pkg.sv
/*
  Shared types of the processor port.
  Assumes hpm_regs.svh beside it.
*/
`default_nettype none
`include "hpm_regs.svh"

package hpm_pkg;
  typedef logic [3:0] hpm_addr_t;
  typedef logic [7:0] hpm_data_t;
endpackage

`default_nettype wire

// File: hpm_port_if.sv
/*
  Pins between the external processor and the device port.
  Assumes the testbench clocks nothing here; it only resolves the data bus.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hpm_regs.svh"

interface hpm_port_if;
  logic op_mode_select; // low host mode, high hardware mode
  logic cpu_type_sel_b1; // bus style bit 1, dir style when high
  logic cpu_type_sel_b2; // bus style bit 2 in host, rail_format_sel in hw
  logic pclk_code; // processor clock in host, coding select in hw
  logic cs_n; // chip select
  logic wr_rw; // write strobe or read/write direction
  logic read_or_data_strobe; // read strobe or data strobe
  logic addr_latch_strobe; // address latch or address strobe
  hpm_pkg::hpm_addr_t addr; // address pins
  hpm_pkg::hpm_data_t host_data_out; // processor drive value
  logic host_data_oe_n; // processor drives data when low
  hpm_pkg::hpm_data_t dev_data_out; // device drive value
  logic dev_data_oe_n; // device drives data when low
  hpm_pkg::hpm_data_t data; // resolved data bus
  logic access_done_ack; // access done, polarity by bus style

  // resolved bus, pulled high when nobody drives
  assign data = !dev_data_oe_n ? dev_data_out :
                !host_data_oe_n ? host_data_out : `HPM_DATA_IDLE;

  modport dev (
    input op_mode_select, cpu_type_sel_b1, cpu_type_sel_b2, pclk_code, cs_n,
    input wr_rw, read_or_data_strobe, addr_latch_strobe, addr, data,
    output dev_data_out, dev_data_oe_n, access_done_ack
  );
  modport host (
    output op_mode_select, cpu_type_sel_b1, cpu_type_sel_b2, pclk_code, cs_n,
    output wr_rw, read_or_data_strobe, addr_latch_strobe, addr,
    output host_data_out, host_data_oe_n,
    input data, access_done_ack
  );
endinterface

`default_nettype wire

// File: hpm_dev.sv
/*
  Device end of the processor port: mode straps, address latch, access
  sequencing and acknowledge, plus hardware-mode line format outputs.
  Assumes all pins are asynchronous to CLK; register contents sit outside
  behind the REG_ port, whose read data answer one cycle after REG_RD.
*/
// Behaviour
// R1 - mode pin low host, high hardware
// R2 - hardware mode ignores port, uses pins
// R3 - host mode uses port pins for control
// R4 - sync styles timed by processor clock
// R5 - absent processor clock held high, async
// R6 - second type pin is style bit 2
// R7 - hw rail pin low dual rail bypass
// R8 - hw single rail: high AMI, low HDB3
// R9 - separate style: write strobe low writes
// R10 - separate style: read strobe low reads
// R11 - direction high read, low write
// R12 - data strobe low marks the transfer
// R13 - latch strobe falling edge captures address
// R14 - address strobe falling edge captures address
// R15 - chip select high ignores all strobes; the address strobe still latches with chip select high here
// R16 - style bits decode async/sync, strobe kinds
// R17 - ack high separate, low direction style
// R18 - four address bits, eight data bits
// R19 - latched address held through access
`timescale 1ns/1ps
`default_nettype none
`include "hpm_regs.svh"

module hpm_dev (
  input wire logic CLK, // 10 MHz clock
  input wire logic RESET, // synchronous, active high
  hpm_port_if.dev PORT, // processor pins
  output logic HOST_MODE, // host mode in force
  output logic BUS_DIR_STYLE, // direction-plus-strobe style
  output logic BUS_SYNC, // synchronous style
  output logic DUAL_RAIL, // hw dual rail, codec bypassed
  output logic AMI_SEL, // hw single rail AMI, else HDB3
  output logic REG_WR, // register write pulse
  output logic REG_RD, // register read pulse
  output hpm_pkg::hpm_addr_t REG_ADDR, // latched address
  output hpm_pkg::hpm_data_t REG_WDATA, // write data
  input wire hpm_pkg::hpm_data_t REG_RDATA // read data, cycle after REG_RD
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 20;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_s1;
  logic [SW-1:0] pin_s2;
  logic [SW-1:0] pin_s3;

  assign pin_raw = {PORT.op_mode_select, PORT.cpu_type_sel_b1, PORT.cpu_type_sel_b2,
                    PORT.pclk_code, PORT.cs_n, PORT.wr_rw, PORT.read_or_data_strobe,
                    PORT.addr_latch_strobe, PORT.addr, PORT.data}; // R18

  // two flops, then a third for edge detection; reset to idle pin levels
  // so no false address strobe edge follows reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pin_s1 <= `HPM_SYNC_IDLE;
      pin_s2 <= `HPM_SYNC_IDLE;
      pin_s3 <= `HPM_SYNC_IDLE;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // ----------------------------------------------------------------
  // pin decode
  // ----------------------------------------------------------------
  wire mode_s = pin_s2[19];
  wire b1_s = pin_s2[18];
  wire b2_s = pin_s2[17];
  wire pclk_s = pin_s2[16];
  wire pclk_q = pin_s3[16];
  wire cs_n_s = pin_s2[15];
  wire wr_s = pin_s2[14];
  wire rds_s = pin_s2[13];
  wire ale_s = pin_s2[12];
  wire ale_q = pin_s3[12];
  wire [3:0] addr_s = pin_s2[11:8];
  wire [7:0] data_s = pin_s2[7:0];

  // mode and style selection
  wire host_mode = (mode_s == `HPM_MODE_HOST); // R1
  wire dir_style = b1_s; // R16
  wire sync_style = b2_s; // R6 R16
  wire rail_format_sel = b2_s; // R7
  wire pclk_rise = pclk_s & ~pclk_q;
  // async styles never look at the clock pin, which the processor end holds high
  wire timing_ok = ~sync_style | pclk_rise; // R4 R5
  wire ale_fall = ale_q & ~ale_s; // R13 R14
  wire cs_act = host_mode & ~cs_n_s; // R3 R15
  // request decode per style
  wire req_low = dir_style ? ~rds_s : (~wr_s | ~rds_s); // R9 R10 R12
  wire req_read = dir_style ? wr_s : ~rds_s; // R10 R11

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_FETCH = 3'b010,
    S_ACK = 3'b100
  } hpm_dev_state_t;

  hpm_dev_state_t state;
  hpm_dev_state_t next_state;
  hpm_pkg::hpm_addr_t addr_hold;
  hpm_pkg::hpm_data_t dout;
  logic ack_on;
  logic drive_n;

  wire idle = (state == S_IDLE);
  wire start = idle & cs_act & req_low & timing_ok; // R4 R15
  wire finish = ~req_low | ~cs_act;

  // register side strobes
  assign REG_RD = start & req_read; // R10 R11
  assign REG_WR = start & ~req_read; // R9 R11
  assign REG_ADDR = addr_hold;
  assign REG_WDATA = data_s;

  // next state
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: begin
        if (start) begin
          next_state = req_read ? S_FETCH : S_ACK;
        end
      end
      S_FETCH: begin
        next_state = S_ACK;
      end
      S_ACK: begin
        if (finish) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    if (!host_mode) begin
      next_state = S_IDLE; // R2
    end
  end

  // state register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // address holding register, frozen during an access
  always_ff @(posedge CLK) begin
    if (RESET) begin
      addr_hold <= '0;
    end else if (host_mode && idle && ale_fall) begin
      addr_hold <= addr_s; // R13 R14 R19
    end
  end

  // read data capture and bus drive
  always_ff @(posedge CLK) begin
    if (RESET) begin
      dout <= `HPM_DATA_IDLE;
      drive_n <= 1'b1;
    end else begin
      if (state == S_FETCH) begin
        dout <= REG_RDATA;
        drive_n <= 1'b0; // R18
      end else if (next_state == S_IDLE) begin
        drive_n <= 1'b1;
      end
    end
  end

  // completion flag
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ack_on <= 1'b0;
    end else begin
      ack_on <= (next_state == S_ACK);
    end
  end

  assign PORT.dev_data_out = dout;
  assign PORT.dev_data_oe_n = drive_n;
  // polarity follows the bus style
  assign PORT.access_done_ack = dir_style ? ~ack_on : ack_on; // R17

  // ----------------------------------------------------------------
  // mode and line format outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      HOST_MODE <= 1'b0;
      BUS_DIR_STYLE <= 1'b0;
      BUS_SYNC <= 1'b0;
      DUAL_RAIL <= 1'b0;
      AMI_SEL <= 1'b0;
    end else begin
      HOST_MODE <= host_mode; // R1 R3
      BUS_DIR_STYLE <= host_mode & dir_style; // R16
      BUS_SYNC <= host_mode & sync_style; // R16
      DUAL_RAIL <= ~host_mode & ~rail_format_sel; // R2 R7
      AMI_SEL <= ~host_mode & rail_format_sel & pclk_s; // R8
    end
  end

endmodule

`default_nettype wire

// File: hpm_host.sv
/*
  Processor end of the port: drives mode straps, generates the processor
  clock in synchronous styles, and runs one access per command in host mode.
  Assumes the device end answers through the acknowledge pin; pins from
  the device are asynchronous and pass two flops.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hpm_regs.svh"

module hpm_host (
  input wire logic CLK, // 10 MHz clock
  input wire logic RESET, // synchronous, active high
  hpm_port_if.host PORT, // processor pins
  input wire logic CFG_HW_MODE, // strap hardware mode
  input wire logic CFG_DIR_STYLE, // direction-plus-strobe style
  input wire logic CFG_SYNC, // synchronous style, clock driven
  input wire logic CFG_RAIL_SINGLE, // hw single rail format
  input wire logic CFG_AMI, // hw AMI coding
  input wire logic CMD_WR, // write command pulse
  input wire logic CMD_RD, // read command pulse
  input wire hpm_pkg::hpm_addr_t CMD_ADDR, // command address
  input wire hpm_pkg::hpm_data_t CMD_WDATA, // command write data
  output logic CMD_BUSY, // access in progress
  output logic RSP_VALID, // read data pulse
  output hpm_pkg::hpm_data_t RSP_RDATA // read data
);

  // ----------------------------------------------------------------
  // synchronisers and clock divider
  // ----------------------------------------------------------------
  logic [8:0] in_s1;
  logic [8:0] in_s2;
  logic pclk;
  logic [3:0] div_cnt;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      in_s1 <= '0;
      in_s2 <= '0;
    end else begin
      in_s1 <= {PORT.access_done_ack, PORT.data};
      in_s2 <= in_s1;
    end
  end

  // processor clock from a divider enable, held high when async
  wire div_tick = (div_cnt == 4'(`HPM_PCLK_HALF_CYC - 1));
  always_ff @(posedge CLK) begin
    if (RESET) begin
      div_cnt <= '0;
      pclk <= 1'b1;
    end else begin
      div_cnt <= div_tick ? 4'h0 : div_cnt + 4'h1;
      pclk <= (CFG_SYNC && div_tick) ? ~pclk : (CFG_SYNC ? pclk : 1'b1); // R4 R5
    end
  end

  wire ack_active = CFG_DIR_STYLE ? ~in_s2[8] : in_s2[8];

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_ADDR = 5'b00010,
    H_LATCH = 5'b00100,
    H_STROBE = 5'b01000,
    H_RELEASE = 5'b10000
  } hpm_host_state_t;

  hpm_host_state_t state;
  logic [3:0] cnt;
  logic is_read;
  logic cs_n;
  logic wr_rw;
  logic rds;
  logic ale;
  logic oe_n;
  hpm_pkg::hpm_addr_t addr;
  hpm_pkg::hpm_data_t wdata;

  wire cnt_done = (cnt == 4'h0);
  wire cmd = (CMD_WR | CMD_RD) & ~CFG_HW_MODE;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= H_IDLE;
      cnt <= '0;
      is_read <= 1'b0;
      cs_n <= 1'b1;
      wr_rw <= 1'b1;
      rds <= 1'b1;
      ale <= 1'b0;
      oe_n <= 1'b1;
      addr <= '0;
      wdata <= '0;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= '0;
    end else begin
      RSP_VALID <= 1'b0;
      cnt <= cnt_done ? cnt : cnt - 4'h1;
      unique case (state)
        H_IDLE: begin
          if (cmd) begin
            is_read <= CMD_RD;
            addr <= CMD_ADDR;
            wdata <= CMD_WDATA;
            ale <= 1'b1;
            cnt <= 4'(`HPM_ALE_CYC);
            state <= H_ADDR;
          end
        end
        H_ADDR: begin
          if (cnt_done) begin
            ale <= 1'b0; // R13 R14
            cnt <= 4'(`HPM_ALE_CYC);
            state <= H_LATCH;
          end
        end
        H_LATCH: begin
          if (cnt_done) begin
            cs_n <= 1'b0; // R15
            if (CFG_DIR_STYLE) begin
              wr_rw <= is_read; // R11
              rds <= 1'b0; // R12
            end else begin
              wr_rw <= is_read; // R9
              rds <= ~is_read; // R10
            end
            oe_n <= is_read;
            state <= H_STROBE;
          end
        end
        H_STROBE: begin
          if (ack_active) begin
            RSP_RDATA <= in_s2[7:0];
            RSP_VALID <= is_read;
            cs_n <= 1'b1;
            wr_rw <= 1'b1;
            rds <= 1'b1;
            oe_n <= 1'b1;
            state <= H_RELEASE;
          end
        end
        H_RELEASE: begin
          if (!ack_active) begin
            state <= H_IDLE;
          end
        end
      endcase
    end
  end

  assign CMD_BUSY = (state != H_IDLE);

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  assign PORT.op_mode_select = CFG_HW_MODE;
  assign PORT.cpu_type_sel_b1 = CFG_DIR_STYLE;
  assign PORT.cpu_type_sel_b2 = CFG_HW_MODE ? CFG_RAIL_SINGLE : CFG_SYNC;
  assign PORT.pclk_code = CFG_HW_MODE ? CFG_AMI : pclk;
  assign PORT.cs_n = cs_n;
  assign PORT.wr_rw = wr_rw;
  assign PORT.read_or_data_strobe = rds;
  assign PORT.addr_latch_strobe = ale;
  assign PORT.addr = addr;
  assign PORT.host_data_out = wdata;
  assign PORT.host_data_oe_n = oe_n;

endmodule

`default_nettype wire

// File: hpm_props.sv
/*
  Concurrent checks on the processor port pins between both ends.
  Assumes the testbench instantiates it beside the port interface.
*/
`timescale 1ns/1ps
`default_nettype none

module hpm_props (
  input wire logic CLK, // clock
  input wire logic RESET, // sync reset, active high
  input wire logic op_mode_select, // mode pin
  input wire logic cpu_type_sel_b1, // direction style
  input wire logic cpu_type_sel_b2, // sync style
  input wire logic pclk_code, // processor clock
  input wire logic cs_n, // chip select
  input wire logic wr_rw, // write or direction
  input wire logic read_or_data_strobe, // read or data strobe
  input wire logic addr_latch_strobe, // address strobe
  input wire hpm_pkg::hpm_addr_t addr, // address pins
  input wire logic host_data_oe_n, // host drives data
  input wire logic dev_data_oe_n, // device drives data
  input wire logic access_done_ack // acknowledge
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  // host mode held long enough for the straps to settle
  sequence s_host;
    (!op_mode_select)[*5];
  endsequence
  // port idle with a steady style
  sequence s_quiet;
    (cs_n && !op_mode_select && $stable(cpu_type_sel_b1))[*6];
  endsequence
  // end of an access
  sequence s_end;
    $rose(cs_n);
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_ACK_SEP_CS: assert property (s_host ##0 ($rose(access_done_ack) && !cpu_type_sel_b1
    && !$past(cpu_type_sel_b1, 4)) |-> !$past(cs_n, 3))
    else $error("separate style ack without chip select");
  AST_ACK_DIR_CS: assert property (s_host ##0 ($fell(access_done_ack) && cpu_type_sel_b1
    && $past(cpu_type_sel_b1, 4)) |-> !$past(cs_n, 3) && !$past(read_or_data_strobe, 3))
    else $error("direction style ack without strobe");
  AST_ACK_IDLE: assert property (s_quiet |-> access_done_ack == cpu_type_sel_b1)
    else $error("ack not idle while deselected");
  AST_HW_NO_DRIVE: assert property (op_mode_select[*5] |-> dev_data_oe_n)
    else $error("device drives data in hardware mode");
  AST_DEV_DRIVE_READ: assert property ($fell(dev_data_oe_n) |-> !$past(cs_n, 3)
    && $past(wr_rw, 3) && !$past(read_or_data_strobe, 3))
    else $error("device drives data outside a read");
  AST_DEV_RELEASE: assert property (s_end |-> ##[1:4] dev_data_oe_n)
    else $error("device keeps driving after access");
  AST_HOST_DRIVE_WR: assert property (!host_data_oe_n |-> !cs_n && !wr_rw)
    else $error("host drives data outside a write");
  AST_ALE_IDLE: assert property ($fell(addr_latch_strobe) |-> cs_n && $stable(addr))
    else $error("address strobe falls during access");
  AST_ADDR_HELD: assert property ((!cs_n)[*2] |-> $stable(addr))
    else $error("address moves during access");
  AST_PCLK_ASYNC: assert property ((!op_mode_select && !cpu_type_sel_b2)[*3] |-> pclk_code)
    else $error("processor clock not high in async style");
  AST_SEP_ONE_STROBE: assert property (!op_mode_select && !cpu_type_sel_b1
    |-> wr_rw || read_or_data_strobe)
    else $error("both strobes low");
endmodule

`default_nettype wire

// File: tb_host_port_mode_control.sv
/*
  Testbench joining processor end and device end over the port.
  Assumes the device register contents are modelled here as sixteen bytes.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_host_port_mode_control;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic cfg_hw = 1'b0;
  logic cfg_dir = 1'b0;
  logic cfg_sync = 1'b0;
  logic cfg_rail = 1'b0;
  logic cfg_ami = 1'b0;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  hpm_pkg::hpm_addr_t cmd_addr = 4'h0;
  hpm_pkg::hpm_data_t cmd_wdata = 8'h00;
  hpm_pkg::hpm_data_t reg_rdata = 8'h00;
  logic busy, rsp_valid, host_mode, dir_style, sync_style, dual_rail, ami_sel, reg_wr, reg_rd;
  hpm_pkg::hpm_addr_t reg_addr;
  hpm_pkg::hpm_data_t rsp_rdata, reg_wdata;
  hpm_pkg::hpm_data_t mem [16];
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int wr_cnt = 0;
  int rsp_cnt = 0;

  always #50 CLK = ~CLK;

  hpm_port_if bus ();
  hpm_dev i_hpm_dev (.CLK(CLK), .RESET(RESET), .PORT(bus), .HOST_MODE(host_mode),
    .BUS_DIR_STYLE(dir_style), .BUS_SYNC(sync_style), .DUAL_RAIL(dual_rail),
    .AMI_SEL(ami_sel), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata));
  hpm_host i_hpm_host (.CLK(CLK), .RESET(RESET), .PORT(bus), .CFG_HW_MODE(cfg_hw),
    .CFG_DIR_STYLE(cfg_dir), .CFG_SYNC(cfg_sync), .CFG_RAIL_SINGLE(cfg_rail),
    .CFG_AMI(cfg_ami), .CMD_WR(cmd_wr), .CMD_RD(cmd_rd), .CMD_ADDR(cmd_addr),
    .CMD_WDATA(cmd_wdata), .CMD_BUSY(busy), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata));
  hpm_props i_hpm_props (.CLK(CLK), .RESET(RESET), .op_mode_select(bus.op_mode_select),
    .cpu_type_sel_b1(bus.cpu_type_sel_b1), .cpu_type_sel_b2(bus.cpu_type_sel_b2),
    .pclk_code(bus.pclk_code), .cs_n(bus.cs_n), .wr_rw(bus.wr_rw),
    .read_or_data_strobe(bus.read_or_data_strobe), .addr_latch_strobe(bus.addr_latch_strobe),
    .addr(bus.addr), .host_data_oe_n(bus.host_data_oe_n), .dev_data_oe_n(bus.dev_data_oe_n),
    .access_done_ack(bus.access_done_ack));

  // register contents behind the device, read data one cycle late
  always @(posedge CLK) begin
    if (reg_wr) begin
      mem[reg_addr] <= reg_wdata;
      wr_cnt++;
    end
    if (reg_rd) reg_rdata <= mem[reg_addr];
    if (rsp_valid) rsp_cnt++;
  end

  // ----------------------------------------------------------------
  // reporting and comparison
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic err(input string msg);
    errors++;
    $display("Error %0t: %s", $time, msg);
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) err(what);
  endtask
  task automatic chk8(input hpm_pkg::hpm_data_t got, input hpm_pkg::hpm_data_t exp,
    input string what);
    samples_checked++;
    if (got !== exp) err(what);
  endtask

  // one command to the processor end, then wait for it to finish
  task automatic acc(input logic wr, input hpm_pkg::hpm_addr_t a, input hpm_pkg::hpm_data_t d);
    int n;
    n = 0;
    @(posedge CLK);
    cmd_wr <= wr;
    cmd_rd <= !wr;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge CLK);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    do begin
      @(posedge CLK);
      #1;
      n++;
    end while (busy && n < 300);
    if (n == 300) err("access never finished");
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // writes and reads at both address ends in all four bus styles
  task automatic t_styles();
    hpm_pkg::hpm_data_t d;
    for (int s = 0; s < 4; s++) begin
      @(posedge CLK);
      cfg_dir <= s[0];
      cfg_sync <= s[1];
      repeat (6) @(posedge CLK);
      #1;
      chk1(host_mode, 1'b1, "host mode flag");
      chk1(dir_style, s[0], "bus style flag");
      chk1(sync_style, s[1], "sync style flag");
      chk1(dual_rail, 1'b0, "rail format in host mode");
      chk1(ami_sel, 1'b0, "line coding in host mode");
      d = 8'hc0 + 8'(s);
      acc(1'b1, 4'hf, d);
      chk8(mem[4'hf], d, "write data at top address");
      acc(1'b1, 4'h0, ~d);
      chk8(mem[4'h0], ~d, "write data at address zero");
      acc(1'b0, 4'hf, 8'h00);
      chk8(rsp_rdata, d, "read data at top address");
      acc(1'b0, 4'h0, 8'h00);
      chk8(rsp_rdata, ~d, "read data at address zero");
    end
    chk1(rsp_cnt == 8, 1'b1, "read response count");
    $display("test styles done");
  endtask

  // hardware mode straps, refused writes, then back to host
  task automatic t_hw();
    int n;
    n = wr_cnt;
    for (int s = 0; s < 4; s++) begin
      @(posedge CLK);
      cfg_hw <= 1'b1;
      cfg_rail <= s[0];
      cfg_ami <= s[1];
      repeat (6) @(posedge CLK);
      #1;
      chk1(host_mode, 1'b0, "hardware mode flag");
      chk1(dual_rail, !s[0], "rail format");
      chk1(ami_sel, s[0] && s[1], "line coding");
      chk1(dir_style, 1'b0, "bus style in hardware mode");
      chk1(sync_style, 1'b0, "sync style in hardware mode");
      acc(1'b1, 4'h5, 8'h5a);
    end
    chk1(wr_cnt == n, 1'b1, "write taken in hardware mode");
    @(posedge CLK);
    cfg_hw <= 1'b0;
    repeat (6) @(posedge CLK);
    acc(1'b0, 4'hf, 8'h00);
    chk8(rsp_rdata, 8'hc3, "read after return to host");
    $display("test hardware mode done");
  endtask

  // cut a hang short
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      err("run too long");
      end_sim();
    end
  end

  initial begin
    repeat (6) @(posedge CLK);
    RESET <= 1'b0;
    repeat (3) @(posedge CLK);
    t_styles();
    t_hw();
    end_sim();
  end
endmodule

`default_nettype wire
